// [src/prefr_pkg.sv]
// package for the rail enable and suspend record register bank
// assumes one core clock domain; sizes and offsets shared by every module

package prefr_pkg;

    // register subaddresses on the internal register port
    localparam logic [7:0] PREFR_RECORD_ADDR = 8'h07;   // suspend_rail_record
    localparam logic [7:0] PREFR_UNLOCK_ADDR = 8'h10;   // unlock_key
    localparam logic [7:0] PREFR_ENABLE_ADDR = 8'h11;   // converter_enable

    // reset values
    localparam logic [7:0] PREFR_RECORD_RST = 8'h00;    // record starts clear
    localparam logic [5:0] PREFR_ENABLE_RST = 6'h00;    // every converter off
    localparam logic [7:0] PREFR_UNLOCK_READ = 8'h00;   // unlock_key always reads this

    // field layout of converter_enable
    localparam int PREFR_EN_BITS = 6;                   // converter1..converter6
    localparam int PREFR_SEQ_BITS = 5;                  // sequencer owns converter1..5
    localparam int PREFR_C5_POS = 4;                    // converter5_enable
    localparam int PREFR_C6_POS = 5;                    // converter6_enable

    // default unlock value; arbitrary, the real key is set by parameter
    localparam logic [7:0] PREFR_UNLOCK_KEY_DEF = 8'h5A;

endpackage : prefr_pkg

// [src/prefr_record.sv]
// suspend record: which outputs were on in suspend, caught at power-up
// assumes the sequencer gives a one-cycle power-up pulse on core_clk

`timescale 1ns/1ps
`default_nettype none

module prefr_record
    import prefr_pkg::*;
(
    input wire logic core_clk,          // core clock
    input wire logic reset_n,           // synchronous reset, active low
    input wire logic power_up,          // one-cycle power-up transition
    input wire logic from_suspend,      // that power-up left suspend
    input wire logic [7:0] suspend_on,  // outputs enabled during suspend
    output logic [7:0] record           // captured record
);

    logic [7:0] next_record;            // value taken at power-up

    // from off every bit clears; from suspend each bit mirrors its output
    assign next_record = from_suspend ? suspend_on : 8'h00;  // [RULE_02] [RULE_03]

    // only the power-up pulse moves the record; host writes never reach it
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            record <= PREFR_RECORD_RST; // [RULE_01]
        else if (power_up)
            record <= next_record;      // [RULE_14]
    end

endmodule : prefr_record

`default_nettype wire

// [src/prefr_regs.sv]
// register bank: suspend record, unlock key and converter enables
// assumes an upstream serial-bus engine on core_clk giving one-cycle
// read and write strobes, and a power sequencer on the same clock

`timescale 1ns/1ps
`default_nettype none

// Function
// RULE_01: record register at 0x7, read-only, resets zero
// RULE_02: suspend power-up sets bits of enabled outputs
// RULE_03: off power-up or disabled output clears bit
// RULE_04: unlock register at 0x10 always reads zero
// RULE_05: full unlock byte grants protected access
// RULE_06: enable writes ignored unless unlocked first
// RULE_07: enable register at 0x11 resets to zero
// RULE_08: bits 0-5 enable converter1 to converter6
// RULE_09: sequencer overrides converter1-5 enables
// RULE_10: converter5 disable honoured only with seal fresh
// RULE_11: converter6 disable honoured only with seal fresh
// RULE_12: seal status 0 fresh, 1 broken
// RULE_13: enable bits 7:6 read zero, writes ignored
// RULE_14: record held between power-up transitions
module prefr_regs
    import prefr_pkg::*;
#(
    parameter logic [7:0] UNLOCK_KEY = PREFR_UNLOCK_KEY_DEF // arbitrary value
)(
    input wire logic core_clk,              // 250 MHz core clock
    input wire logic reset_n,               // synchronous reset, active low
    input wire logic reg_wr,                // one-cycle register write
    input wire logic reg_rd,                // one-cycle register read
    input wire logic [7:0] reg_addr,        // register subaddress
    input wire logic [7:0] reg_wdata,       // write data
    output logic [7:0] reg_rdata,           // read data, one cycle after reg_rd
    output logic reg_rvalid,                // read data valid pulse
    input wire logic seq_update,            // sequencer writes converter1..5
    input wire logic [4:0] seq_enables,     // sequencer enable values
    input wire logic power_up,              // power-up transition pulse
    input wire logic from_suspend,          // power-up came from suspend
    input wire logic [7:0] suspend_on,      // outputs enabled during suspend
    input wire logic freshness_seal_status, // 0 fresh, 1 broken
    output logic [5:0] converter_enable     // converter1..converter6 enables
);

    prefr_unlock_if unlock_bus ();          // carrier to the unlock gate
    logic [7:0] suspend_rail_record;        // record register contents
    logic [5:0] next_enable;                // enable value for next cycle
    logic [7:0] next_rdata;                 // selected read value

    // write stream goes to the unlock gate so it sees every write
    assign unlock_bus.wr_strobe = reg_wr;
    assign unlock_bus.addr = reg_addr;
    assign unlock_bus.wdata = reg_wdata;

    prefr_unlock #(
        .UNLOCK_KEY (UNLOCK_KEY)
    ) u_unlock (
        .core_clk (core_clk),
        .reset_n (reset_n),
        .bus (unlock_bus.gate)
    );

    prefr_record u_record (
        .core_clk (core_clk),
        .reset_n (reset_n),
        .power_up (power_up),
        .from_suspend (from_suspend),
        .suspend_on (suspend_on),
        .record (suspend_rail_record)
    );

    // address decode
    wire hit_record = (reg_addr == PREFR_RECORD_ADDR);
    wire hit_unlock = (reg_addr == PREFR_UNLOCK_ADDR);
    wire hit_enable = (reg_addr == PREFR_ENABLE_ADDR);

    // a host write lands only when the gate has just been opened
    wire host_we = reg_wr && hit_enable && unlock_bus.granted;  // [RULE_06]

    // seal broken means a host 0 cannot switch the battery-domain rails off;
    // it can still switch them on, so the OR keeps whatever is already set
    wire seal_broken = freshness_seal_status;                   // [RULE_12]
    wire c5_host = seal_broken ?
        (converter_enable[PREFR_C5_POS] | reg_wdata[PREFR_C5_POS]) :
        reg_wdata[PREFR_C5_POS];                                // [RULE_10]
    wire c6_host = seal_broken ?
        (converter_enable[PREFR_C6_POS] | reg_wdata[PREFR_C6_POS]) :
        reg_wdata[PREFR_C6_POS];                                // [RULE_11]
    wire [5:0] host_value = {c6_host, c5_host, reg_wdata[3:0]}; // [RULE_08]

    // host value first, then the sequencer overlays converter1..5; bit 5
    // is never touched by the sequencer, and bits 7:6 are not stored at all
    always_comb
    begin
        next_enable = converter_enable;
        if (host_we)
            next_enable = host_value;                           // [RULE_13]
        if (seq_update)
            next_enable[PREFR_SEQ_BITS-1:0] = seq_enables;      // [RULE_09]
    end

    // enable register
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            converter_enable <= PREFR_ENABLE_RST;               // [RULE_07]
        else
            converter_enable <= next_enable;
    end

    // read mux; unmapped addresses and unlock_key read as zero
    assign next_rdata = hit_record ? suspend_rail_record :      // [RULE_01]
                        hit_unlock ? PREFR_UNLOCK_READ :        // [RULE_04]
                        hit_enable ? {2'b00, converter_enable} : // [RULE_13]
                        8'h00;

    // read data is registered so the serial engine sees a stable byte
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= next_rdata;
        end
    end

    // assertions: each one guards the behaviour stated in the comment just above it
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // a host write to the record register must not move it
    property p_record_ro;
        reg_wr && hit_record && !power_up |=> $stable(suspend_rail_record);
    endproperty
    a_record_ro: assert property (p_record_ro) else $error("record changed by write"); // [RULE_01]

    // power-up from suspend copies the suspend enables
    property p_record_suspend;
        power_up && from_suspend |=> suspend_rail_record == $past(suspend_on);
    endproperty
    a_record_suspend: assert property (p_record_suspend) else $error("record capture wrong"); // [RULE_02]

    // power-up from off clears the record
    property p_record_off;
        power_up && !from_suspend |=> suspend_rail_record == 8'h00;
    endproperty
    a_record_off: assert property (p_record_off) else $error("record not cleared"); // [RULE_03]

    // record holds between transitions
    property p_record_hold;
        !power_up |=> $stable(suspend_rail_record);
    endproperty
    a_record_hold: assert property (p_record_hold) else $error("record moved"); // [RULE_14]

    // unlock register reads zero one cycle later
    property p_unlock_reads_zero;
        reg_rd && hit_unlock |=> reg_rvalid && reg_rdata == 8'h00;
    endproperty
    a_unlock_reads_zero: assert property (p_unlock_reads_zero) else $error("unlock read nonzero"); // [RULE_04]

    // locked writes leave the enables alone
    property p_locked_ignored;
        reg_wr && hit_enable && !unlock_bus.granted && !seq_update
            |=> $stable(converter_enable);
    endproperty
    a_locked_ignored: assert property (p_locked_ignored) else $error("locked write landed"); // [RULE_06]

    // unlocked write with fresh seal lands exactly
    property p_unlocked_write;
        host_we && !seal_broken && !seq_update |=> converter_enable == $past(reg_wdata[5:0]);
    endproperty
    a_unlocked_write: assert property (p_unlocked_write) else $error("write lost"); // [RULE_08]

    // sequencer overrides converter1..5 and leaves converter6
    property p_seq_override;
        seq_update && !host_we |=> converter_enable[4:0] == $past(seq_enables)
            && converter_enable[5] == $past(converter_enable[5]);
    endproperty
    a_seq_override: assert property (p_seq_override) else $error("sequencer ignored"); // [RULE_09]

    // broken seal keeps converter5 on against a host 0
    property p_c5_kept;
        host_we && seal_broken && !seq_update && converter_enable[4]
            |=> converter_enable[4];
    endproperty
    a_c5_kept: assert property (p_c5_kept) else $error("converter5 disabled"); // [RULE_10]

    // broken seal keeps converter6 on against a host 0
    property p_c6_kept;
        host_we && seal_broken && converter_enable[5] |=> converter_enable[5];
    endproperty
    a_c6_kept: assert property (p_c6_kept) else $error("converter6 disabled"); // [RULE_11]

    // reserved bits read as zero
    property p_reserved_zero;
        reg_rd && hit_enable |=> reg_rdata[7:6] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // [RULE_13]

    // reset leaves every converter off
    property p_reset_off;
        @(posedge core_clk) disable iff (1'b0)
        !reset_n |=> converter_enable == 6'h00;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("enables not reset"); // [RULE_07]

    // a read strobe is answered on the very next edge
    property p_rvalid_on;
        reg_rd |=> reg_rvalid;
    endproperty
    a_rvalid_on: assert property (p_rvalid_on) else $error("read unanswered"); // [RULE_04]

    // no strobe, no valid; a stray pulse would hand the serial engine junk
    property p_rvalid_off;
        !reg_rd |=> !reg_rvalid;
    endproperty
    a_rvalid_off: assert property (p_rvalid_off) else $error("stray read valid"); // [RULE_04]

    // read data stands between reads so a slow engine can shift it out
    property p_rdata_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved"); // [RULE_01]

    // a record read returns the record as it stood at the strobe
    property p_record_read;
        reg_rd && hit_record |=> reg_rdata == $past(suspend_rail_record);
    endproperty
    a_record_read: assert property (p_record_read) else $error("bad record read"); // [RULE_01]

    // an enable read returns the stored enables with bits 7:6 clear
    property p_enable_read;
        reg_rd && hit_enable |=> reg_rdata == {2'b00, $past(converter_enable)};
    endproperty
    a_enable_read: assert property (p_enable_read) else $error("bad enable read"); // [RULE_13]

    // no host write of any address moves the record
    property p_record_write;
        reg_wr && !power_up |=> $stable(suspend_rail_record);
    endproperty
    a_record_write: assert property (p_record_write) else $error("record written"); // [RULE_01]

    // converter1..4 always take the host value when the sequencer is idle
    property p_low_write;
        host_we && !seq_update |=> converter_enable[3:0] == $past(reg_wdata[3:0]);
    endproperty
    a_low_write: assert property (p_low_write) else $error("low bits lost"); // [RULE_08]

    // with the seal fresh a host 0 really turns converter5 off
    property p_c5_fresh_off;
        host_we && !seal_broken && !seq_update && !reg_wdata[4] |=> !converter_enable[4];
    endproperty
    a_c5_fresh_off: assert property (p_c5_fresh_off) else $error("c5 not off"); // [RULE_10]

    // with the seal fresh a host 0 really turns converter6 off
    property p_c6_fresh_off;
        host_we && !seal_broken && !reg_wdata[5] |=> !converter_enable[5];
    endproperty
    a_c6_fresh_off: assert property (p_c6_fresh_off) else $error("c6 not off"); // [RULE_11]

    // a broken seal must not stop the host switching converter5 on
    property p_c5_broken_on;
        host_we && seal_broken && !seq_update && reg_wdata[4] |=> converter_enable[4];
    endproperty
    a_c5_broken_on: assert property (p_c5_broken_on) else $error("c5 not on"); // [RULE_10]

    // a broken seal must not stop the host switching converter6 on
    property p_c6_broken_on;
        host_we && seal_broken && reg_wdata[5] |=> converter_enable[5];
    endproperty
    a_c6_broken_on: assert property (p_c6_broken_on) else $error("c6 not on"); // [RULE_11]

    // the sequencer beats a same-cycle host write on converter1..5
    property p_seq_wins;
        seq_update && host_we |=> converter_enable[4:0] == $past(seq_enables);
    endproperty
    a_seq_wins: assert property (p_seq_wins) else $error("host beat sequencer"); // [RULE_09]

    // converter6 still takes the host value while the sequencer acts
    property p_c6_beside_seq;
        seq_update && host_we && !seal_broken |=> converter_enable[5] == $past(reg_wdata[5]);
    endproperty
    a_c6_beside_seq: assert property (p_c6_beside_seq) else $error("c6 lost"); // [RULE_11]

    // with neither writer active the enables must hold
    property p_enable_hold;
        !host_we && !seq_update |=> $stable(converter_enable);
    endproperty
    a_enable_hold: assert property (p_enable_hold) else $error("enables moved"); // [RULE_06]

    // scenarios worth seeing
    c_unlock_write: cover property (host_we);
    c_suspend_capture: cover property (power_up && from_suspend && suspend_on != 8'h00);
    c_seal_block: cover property (host_we && seal_broken && !reg_wdata[5]);
    c_seq_and_host: cover property (host_we && seq_update);
    c_record_off: cover property (power_up && !from_suspend);

endmodule : prefr_regs

`default_nettype wire

// [src/prefr_unlock.sv]
// unlock gate: a write of the key to unlock_key arms one protected write
// assumes write strobes are one cycle wide and on core_clk

`timescale 1ns/1ps
`default_nettype none

module prefr_unlock
    import prefr_pkg::*;
#(
    parameter logic [7:0] UNLOCK_KEY = PREFR_UNLOCK_KEY_DEF // arbitrary value
)(
    input wire logic core_clk,          // core clock
    input wire logic reset_n,           // synchronous reset, active low
    prefr_unlock_if.gate bus            // write stream from the bank
);

    logic armed;                        // key seen, next write may pass
    wire key_write = bus.wr_strobe && (bus.addr == PREFR_UNLOCK_ADDR);
    wire key_match = (bus.wdata == UNLOCK_KEY);  // whole byte compared [RULE_05]

    // any write consumes the arm, so a stray write relocks the bank
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            armed <= 1'b0;
        else if (key_write)
            armed <= key_match;         // [RULE_05]
        else if (bus.wr_strobe)
            armed <= 1'b0;
    end

    assign bus.granted = armed;         // [RULE_06]

    // a matching key write must open exactly the next cycle
    property p_key_opens;
        @(posedge core_clk) disable iff (!reset_n)
        key_write && key_match |=> bus.granted;
    endproperty
    a_key_opens: assert property (p_key_opens) else $error("key did not unlock"); // [RULE_05]

    // a wrong key must leave the bank locked
    property p_bad_key_locks;
        @(posedge core_clk) disable iff (!reset_n)
        key_write && !key_match |=> !bus.granted;
    endproperty
    a_bad_key_locks: assert property (p_bad_key_locks) else $error("wrong key unlocked"); // [RULE_05]

endmodule : prefr_unlock

`default_nettype wire

// [src/prefr_unlock_if.sv]
// carrier between the register bank and its unlock gate
// assumes both ends sit on core_clk

`timescale 1ns/1ps
`default_nettype none

interface prefr_unlock_if;
    logic wr_strobe;        // one-cycle register write
    logic [7:0] addr;       // write subaddress
    logic [7:0] wdata;      // write data
    logic granted;          // protected write allowed now

    modport bank (output wr_strobe, output addr, output wdata, input granted);
    modport gate (input wr_strobe, input addr, input wdata, output granted);
endinterface : prefr_unlock_if

`default_nettype wire

// [testbench/prefr_host.sv]
// host model: a serial-bus engine driving the bank's register port
// assumes one core clock; requests launch just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module prefr_host
    import prefr_pkg::*;
#(
    parameter logic [7:0] UNLOCK_KEY = PREFR_UNLOCK_KEY_DEF // arbitrary value
)(
    input wire logic core_clk,         // core clock
    output var logic reg_wr,           // write strobe
    output var logic reg_rd,           // read strobe
    output var logic [7:0] reg_addr,   // subaddress
    output var logic [7:0] reg_wdata,  // write data
    input wire logic [7:0] reg_rdata,  // read data
    input wire logic reg_rvalid        // read data valid
);
    // idle port at time zero
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // one write; released lines are inverted so a stale value never looks valid
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~addr;
        reg_wdata <= ~data;
    endtask : wr

    // one read; data is taken once the answer edge has settled
    task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic valid);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~addr;
        #1;
        data = reg_rdata;
        valid = reg_rvalid;
    endtask : rd

    // key first, then the protected write as the very next write
    task automatic prot_wr(input logic [7:0] addr, input logic [7:0] data);
        wr(PREFR_UNLOCK_ADDR, UNLOCK_KEY);
        wr(addr, data);
    endtask : prot_wr
endmodule : prefr_host
`default_nettype wire

// [testbench/prefr_regs_bench.sv]
// self-checking bench for the rail enable and suspend record bank
// assumes the host model drives the register port; bench drives the rest
`timescale 1ns/1ps
`default_nettype none
module prefr_regs_bench;
    import prefr_pkg::*;
    localparam logic [7:0] KEY = 8'hC3; // arbitrary key for this run
    logic core_clk = 1'b0; // 250 MHz
    logic reset_n = 1'b0; // held low at start
    logic reg_wr, reg_rd, reg_rvalid, seq_update = 1'b0, power_up = 1'b0;
    logic from_suspend = 1'b0, freshness_seal_status = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, suspend_on = 8'h00;
    logic [4:0] seq_enables = 5'h00;
    logic [5:0] converter_enable;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    always #2 core_clk = ~core_clk; // 4 ns period

    prefr_regs #(.UNLOCK_KEY(KEY)) prefr_regs_inst (.core_clk(core_clk), .reset_n(reset_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .seq_update(seq_update),
        .seq_enables(seq_enables), .power_up(power_up), .from_suspend(from_suspend),
        .suspend_on(suspend_on), .freshness_seal_status(freshness_seal_status),
        .converter_enable(converter_enable));
    prefr_host #(.UNLOCK_KEY(KEY)) prefr_host_inst (.core_clk(core_clk), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    task automatic close_out();
        $display("checks %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    // a hang costs a mismatch; the whole run needs under a hundred cycles
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_errors = n_errors + 1;
            close_out();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // read back a register and judge the valid pulse as well as the data
    task automatic rdchk(input string what, input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        prefr_host_inst.rd(addr, d, v);
        check({what, " valid"}, {7'h00, v}, 8'h01);
        check(what, d, exp);
    endtask : rdchk

    // enables land on the write edge; look after it settles
    task automatic chk_en(input logic [7:0] exp);
        #1;
        check("converter_enable", {2'b00, converter_enable}, exp);
    endtask : chk_en

    task automatic do_reset();
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
    endtask : do_reset

    task automatic pulse_up(input logic fs, input logic [7:0] on);
        @(posedge core_clk);
        power_up <= 1'b1;
        from_suspend <= fs;
        suspend_on <= on;
        @(posedge core_clk);
        power_up <= 1'b0;
    endtask : pulse_up

    task automatic t_reset();
        chk_en(8'h00);
        rdchk("record", PREFR_RECORD_ADDR, 8'h00);
        rdchk("unlock", PREFR_UNLOCK_ADDR, 8'h00);
        rdchk("enable reg", PREFR_ENABLE_ADDR, 8'h00);
        rdchk("unmapped", 8'h33, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_lock();
        prefr_host_inst.wr(PREFR_ENABLE_ADDR, 8'h3F);
        chk_en(8'h00);
        prefr_host_inst.wr(PREFR_UNLOCK_ADDR, ~KEY);
        prefr_host_inst.wr(PREFR_ENABLE_ADDR, 8'h3F);
        chk_en(8'h00);
        // an intervening write spends the grant
        prefr_host_inst.wr(PREFR_UNLOCK_ADDR, KEY);
        prefr_host_inst.wr(PREFR_RECORD_ADDR, 8'hFF);
        prefr_host_inst.wr(PREFR_ENABLE_ADDR, 8'h3F);
        chk_en(8'h00);
        $display("test lock done");
    endtask : t_lock

    task automatic t_unlock();
        prefr_host_inst.prot_wr(PREFR_ENABLE_ADDR, 8'hFF);
        chk_en(8'h3F);
        rdchk("enable reg", PREFR_ENABLE_ADDR, 8'h3F);
        rdchk("unlock", PREFR_UNLOCK_ADDR, 8'h00);
        prefr_host_inst.prot_wr(PREFR_ENABLE_ADDR, 8'h0A);
        chk_en(8'h0A);
        $display("test unlock done");
    endtask : t_unlock

    task automatic t_seal();
        @(posedge core_clk);
        freshness_seal_status <= 1'b1;
        prefr_host_inst.prot_wr(PREFR_ENABLE_ADDR, 8'h3F);
        chk_en(8'h3F);
        prefr_host_inst.prot_wr(PREFR_ENABLE_ADDR, 8'h00);
        chk_en(8'h30);
        @(posedge core_clk);
        freshness_seal_status <= 1'b0;
        prefr_host_inst.prot_wr(PREFR_ENABLE_ADDR, 8'h00);
        chk_en(8'h00);
        $display("test seal done");
    endtask : t_seal

    task automatic t_seq();
        prefr_host_inst.prot_wr(PREFR_ENABLE_ADDR, 8'h3F);
        @(posedge core_clk);
        seq_update <= 1'b1;
        seq_enables <= 5'h0A;
        freshness_seal_status <= 1'b1;
        @(posedge core_clk);
        seq_update <= 1'b0;
        seq_enables <= 5'h15;
        chk_en(8'h2A);
        @(posedge core_clk);
        freshness_seal_status <= 1'b0;
        // sequencer and host land on one edge: host keeps only bit 5
        fork
            prefr_host_inst.prot_wr(PREFR_ENABLE_ADDR, 8'h20);
            begin
                repeat (3) @(posedge core_clk);
                seq_update <= 1'b1;
                @(posedge core_clk);
                seq_update <= 1'b0;
            end
        join
        chk_en(8'h35);
        $display("test sequencer done");
    endtask : t_seq

    task automatic t_record();
        pulse_up(1'b1, 8'h81);
        rdchk("record", PREFR_RECORD_ADDR, 8'h81);
        prefr_host_inst.prot_wr(PREFR_RECORD_ADDR, 8'h00);
        rdchk("record", PREFR_RECORD_ADDR, 8'h81);
        @(posedge core_clk);
        suspend_on <= 8'hFF;
        rdchk("record", PREFR_RECORD_ADDR, 8'h81);
        pulse_up(1'b1, 8'h7E);
        rdchk("record", PREFR_RECORD_ADDR, 8'h7E);
        pulse_up(1'b0, 8'hFF);
        rdchk("record", PREFR_RECORD_ADDR, 8'h00);
        pulse_up(1'b1, 8'h5C);
        rdchk("record", PREFR_RECORD_ADDR, 8'h5C);
        do_reset();
        rdchk("record", PREFR_RECORD_ADDR, 8'h00);
        chk_en(8'h00);
        $display("test record done");
    endtask : t_record

    // main sequence: reset held two cycles, then each scenario in turn
    initial
    begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        t_reset();
        t_lock();
        t_unlock();
        t_seal();
        t_seq();
        t_record();
        close_out();
    end
endmodule : prefr_regs_bench
`default_nettype wire
